// ===== hdl/fpc_unit.v
// Fixed-point compare unit with an AXI4-Lite register front end.
// Assumes one clock, synchronous active-low reset, one master.
`include "fpc_defs.vh"

module fpc_unit #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // Write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // Read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Condition register view for dependent readers
  output wire [31:0] cond_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // Architectural state

  reg [31:0] instr_q;
  reg [WIDTH-1:0] src1_q;
  reg [WIDTH-1:0] src2_q;
  reg [31:0] xer_q;
  reg [31:0] cr_q;
  reg illegal_q;
  reg [7:0] count_q;

  wire is_compare;
  wire [2:0] field_sel;
  wire [3:0] result_field;

  fpc_compare_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .instr(instr_q),
    .src1(src1_q),
    .src2(src2_q),
    .summary_overflow(xer_q[`FPC_XER_SO_BIT]),
    .is_compare(is_compare),
    .target_field_selector(field_sel),
    .result_field(result_field)
  );

  assign cond_reg = cr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken together once both present

  reg aw_held_q;
  reg [11:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_q || aw_fire;
  wire w_have = w_held_q || w_fire;
  wire [11:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;

  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (val & msk);
    end
  endfunction

  wire wr_map = (wr_addr == `FPC_REG_CTRL) || (wr_addr == `FPC_REG_INSTR) ||
                (wr_addr == `FPC_REG_SRC1) || (wr_addr == `FPC_REG_SRC2) ||
                (wr_addr == `FPC_REG_XER) || (wr_addr == `FPC_REG_CR);
  // Writing bit 0 of the control word launches the compare held in the instruction register
  wire exec_go = wr_go && (wr_addr == `FPC_REG_CTRL) && wr_strb[0] && wr_data[0];

  ////////////////////////////////////////////////////////////////////////////
  // Condition register update: a compare moves only the selected nibble

  // One decoded select per field keeps a compare away from every other nibble
  wire [7:0] field_hit = 8'h01 << field_sel;
  wire [31:0] cr_wr = merge(cr_q, wr_data, wmask);
  wire [31:0] cr_d;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_field
      // Field n sits at bits 31-4n..28-4n, so field 0 is the top nibble
      assign cr_d[31-4*g -: 4] = (exec_go && is_compare && field_hit[g]) ? result_field :
                                 (wr_go && (wr_addr == `FPC_REG_CR)) ? cr_wr[31-4*g -: 4] : cr_q[31-4*g -: 4];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FPC_RESP_OKAY;
      instr_q <= 32'h00000000;
      src1_q <= {WIDTH{1'b0}};
      src2_q <= {WIDTH{1'b0}};
      xer_q <= `FPC_XER_RESET;
      cr_q <= `FPC_CR_RESET;
      illegal_q <= 1'b0;
      count_q <= 8'h00;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `FPC_RESP_OKAY : `FPC_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
      end
      if (wr_go && (wr_addr == `FPC_REG_INSTR)) begin
        instr_q <= merge(instr_q, wr_data, wmask);
      end
      if (wr_go && (wr_addr == `FPC_REG_SRC1)) begin
        src1_q <= merge(src1_q, wr_data, wmask);
      end
      if (wr_go && (wr_addr == `FPC_REG_SRC2)) begin
        src2_q <= merge(src2_q, wr_data, wmask);
      end
      // Compares only read this register; software alone writes it
      if (wr_go && (wr_addr == `FPC_REG_XER)) begin
        xer_q <= merge(xer_q, wr_data, wmask);
      end
      cr_q <= cr_d;
      if (exec_go) begin
        illegal_q <= !is_compare;
        if (is_compare) begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data

  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FPC_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `FPC_RESP_OKAY;
        case (s_axi_araddr)
          `FPC_REG_CTRL: s_axi_rdata <= 32'h00000000;
          `FPC_REG_INSTR: s_axi_rdata <= instr_q;
          `FPC_REG_SRC1: s_axi_rdata <= src1_q;
          `FPC_REG_SRC2: s_axi_rdata <= src2_q;
          `FPC_REG_XER: s_axi_rdata <= xer_q;
          `FPC_REG_CR: s_axi_rdata <= cr_q;
          `FPC_REG_STATUS: s_axi_rdata <= {23'h000000, illegal_q, count_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FPC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

// ===== inc/fpc_defs.vh
// Constants for the fixed-point compare unit: opcodes, field positions, register map.
// Assumes instruction bits are numbered 0 (msb) to 31 (lsb) as in the architecture.
`ifndef FPC_DEFS_VH
`define FPC_DEFS_VH

// Instruction fields, little-endian bit index = 31 - documented bit
`define FPC_PRIMARY_HI 31
`define FPC_PRIMARY_LO 26
`define FPC_FIELD_HI 25
`define FPC_FIELD_LO 23
`define FPC_SIZE_BIT 21
`define FPC_SRC1_HI 20
`define FPC_SRC1_LO 16
`define FPC_SRC2_HI 15
`define FPC_SRC2_LO 11
`define FPC_EXT_HI 10
`define FPC_EXT_LO 1
`define FPC_IMM_HI 15
`define FPC_IMM_LO 0

`define FPC_OP_REG 6'h1f
`define FPC_OP_IMM 6'h0b
`define FPC_EXT_SIGNED 10'h000
`define FPC_EXT_UNSIGNED 10'h020

// Condition field layout, little-endian within the 4-bit nibble
`define FPC_BIT_LESS 3
`define FPC_BIT_GREATER 2
`define FPC_BIT_SAME 1
`define FPC_BIT_SO 0

// AXI4-Lite register map (byte addresses)
`define FPC_REG_CTRL 12'h000
`define FPC_REG_INSTR 12'h004
`define FPC_REG_SRC1 12'h008
`define FPC_REG_SRC2 12'h00c
`define FPC_REG_XER 12'h010
`define FPC_REG_CR 12'h014
`define FPC_REG_STATUS 12'h018

`define FPC_CR_RESET 32'h00000000
`define FPC_XER_RESET 32'h00000000
`define FPC_XER_SO_BIT 31

`define FPC_RESP_OKAY 2'h0
`define FPC_RESP_SLVERR 2'h2

`endif

// ===== hdl/fpc_compare_core.v
// Combinational decode and compare for one instruction word.
// Assumes operands are already read from the register file.
`include "fpc_defs.vh"

module fpc_compare_core #(
  parameter WIDTH = 32
) (
  // Instruction and operands
  input wire [31:0] instr,
  input wire [WIDTH-1:0] src1,
  input wire [WIDTH-1:0] src2,
  input wire summary_overflow,
  // Result
  output reg is_compare,
  output reg [2:0] target_field_selector,
  output reg [3:0] result_field
);

  reg [5:0] primary;
  reg [9:0] ext;
  reg is_reg;
  reg is_unsigned;
  reg [WIDTH-1:0] rhs;
  reg less_flag;
  reg greater_flag;
  reg same_flag;

  always @* begin
    primary = instr[`FPC_PRIMARY_HI:`FPC_PRIMARY_LO];
    ext = instr[`FPC_EXT_HI:`FPC_EXT_LO];
    // Bit 9 is never looked at; bit 31 only as the low bit of the immediate
    is_reg = (primary == `FPC_OP_REG) && ((ext == `FPC_EXT_SIGNED) || (ext == `FPC_EXT_UNSIGNED));
    is_unsigned = is_reg && (ext == `FPC_EXT_UNSIGNED);
    is_compare = is_reg || (primary == `FPC_OP_IMM);
    target_field_selector = instr[`FPC_FIELD_HI:`FPC_FIELD_LO];
    if (is_reg) begin
      rhs = src2;
    end else begin
      rhs = {{(WIDTH-16){instr[`FPC_IMM_HI]}}, instr[`FPC_IMM_HI:`FPC_IMM_LO]};
    end
    if (is_unsigned) begin
      less_flag = src1 < rhs;
      greater_flag = src1 > rhs;
    end else begin
      less_flag = $signed(src1) < $signed(rhs);
      greater_flag = $signed(src1) > $signed(rhs);
    end
    same_flag = src1 == rhs;
    result_field = {less_flag, greater_flag, same_flag, summary_overflow};
  end

endmodule

// ===== tb/fpc_unit_chk.sv
// Assertion checker for the compare unit, bound to its top module.
// Assumes a master that offers write address and data together.
`include "fpc_defs.vh"
module fpc_unit_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus signals
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  // Condition register
  input wire [31:0] cond_reg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] prev_q;
  logic [7:0] chg;
  logic [7:0] hot;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Per-field change and flag one-hot view of the last edge
  always @(posedge aclk) prev_q <= cond_reg;
  always_comb begin
    for (int f = 0; f < 8; f++) begin
      chg[f] = cond_reg[4*f+:4] != prev_q[4*f+:4];
      hot[f] = $onehot(cond_reg[4*f+1+:3]);
    end
  end
  ////////////////////////////////////////////////////////////////
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h018
    |=> s_axi_rresp == `FPC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  ro_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `FPC_REG_STATUS
    |=> s_axi_bresp == `FPC_RESP_SLVERR) else $error("status write not refused");
  one_field_a: assert property ($past(s_axi_wvalid && s_axi_awaddr == `FPC_REG_CTRL) |-> $countones(chg) <= 1)
    else $error("compare changed more than one field");
  flags_hot_a: assert property ($past(s_axi_wvalid && s_axi_awaddr == `FPC_REG_CTRL) |-> (chg & ~hot) == 8'h00)
    else $error("compare field flags not one-hot");
  cr_quiet_a: assert property ($past(!s_axi_wvalid) |-> chg == 8'h00)
    else $error("condition register changed without a write");
endmodule
bind fpc_unit fpc_unit_chk u_fpc_unit_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .cond_reg(cond_reg));

// ===== tb/testbench.sv
// Self-checking bench: runs compares through the AXI4-Lite registers.
// Assumes fpc_defs.vh on the include path and the bound checker.
`include "fpc_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, so_q;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, cond_reg, cr_exp, rd_val;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [31:0] ins_t [7];
  logic [31:0] a_t [7];
  logic [31:0] b_t [7];
  logic so_t [7];
  int n_fail, check_count, cycles;
  fpc_unit u_fpc_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .cond_reg(cond_reg));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mk(input logic [5:0] op, input logic [2:0] fd, input logic [15:0] lo);
    return {op, fd, 7'h00, lo};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Each channel is released at its own handshake edge
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask
  // Expected field worked out from opcode, extended opcode and operands
  task automatic exe(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] bb;
    logic uns, ok;
    bb = ins[31:26] == 6'h0b ? {{16{ins[15]}}, ins[15:0]} : b;
    uns = ins[31:26] == 6'h1f && ins[10:1] == 10'h020;
    ok = ins[31:26] == 6'h0b || uns || (ins[31:26] == 6'h1f && ins[10:1] == 10'h000);
    wr(`FPC_REG_INSTR, ins, `FPC_RESP_OKAY);
    wr(`FPC_REG_SRC1, a, `FPC_RESP_OKAY);
    wr(`FPC_REG_SRC2, b, `FPC_RESP_OKAY);
    wr(`FPC_REG_CTRL, 32'h1, `FPC_RESP_OKAY);
    if (ok) begin
      cr_exp[31-4*ins[25:23] -: 4] = uns ? {a < bb, a > bb, a == bb, so_q}
        : {$signed(a) < $signed(bb), $signed(a) > $signed(bb), a == bb, so_q};
    end
    chk(cond_reg, cr_exp);
    rd(`FPC_REG_CR);
    chk(rd_val, cr_exp);
    chk(rd_resp, `FPC_RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Ceiling well above the hundred or so cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, so_q} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cr_exp} = '0;
    {n_fail, check_count, cycles} = '0;
    // Size bit kept zero in every word; row 2 and 4 set reserved bits
    ins_t = '{mk(6'h1f, 3'h0, 16'h0), mk(6'h1f, 3'h7, 16'h0) | 32'h00400001, mk(6'h1f, 3'h3, 16'h40),
      mk(6'h1f, 3'h3, 16'h41), mk(6'h0b, 3'h5, 16'hfff0), mk(6'h0b, 3'h1, 16'hffff), mk(6'h1f, 3'h2, 16'h426)};
    a_t = '{32'hffffffe7, 32'h80000000, 32'hffff0000, 32'h5, 32'hfffffff0, 32'h11, 32'h1};
    b_t = '{32'h11, 32'h7fffffff, 32'h7fff0000, 32'h5, 32'h0, 32'h0, 32'h2};
    so_t = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FPC_REG_CR);
    chk(rd_val, `FPC_CR_RESET);
    for (int i = 0; i < 7; i++) begin
      so_q = so_t[i];
      wr(`FPC_REG_XER, {so_q, 31'h0}, `FPC_RESP_OKAY);
      exe(ins_t[i], a_t[i], b_t[i]);
    end
    rd(`FPC_REG_XER);
    chk(rd_val, {so_q, 31'h0});
    rd(`FPC_REG_STATUS);
    chk(rd_val, 32'h00000106);
    wr(`FPC_REG_STATUS, 32'h0, `FPC_RESP_SLVERR);
    rd(12'h100);
    chk(rd_resp, `FPC_RESP_SLVERR);
    chk(rd_val, 32'h0);
    wr(`FPC_REG_CR, 32'h12345678, `FPC_RESP_OKAY);
    rd(`FPC_REG_CR);
    chk(rd_val, 32'h12345678);
    stop_test();
  end
endmodule
